// *** core/pressure_word_cfg.svh ***
// Constants for the parallel pressure word output
`ifndef PRESSURE_WORD_CFG_SVH
`define PRESSURE_WORD_CFG_SVH
`define PW_WIDTH        21
`define PW_SIGNED_MAX   16'sh7fff
`define PW_SIGNED_MIN   -16'sh7fff
`define PW_BIN_MAX      17'h0ffff
`define PW_BCD_MAX      17'h186a0
`define PW_BCD_DIGITS   5
`define PW_SETTLE_NS    100
`define PW_CLK_MHZ      50
`define PW_SETTLE_CYC   ((`PW_SETTLE_NS * `PW_CLK_MHZ + 999) / 1000)
`define PW_ZERO_WORD    21'h000000
`endif

// *** core/pressure_word_pkg.sv ***
// Types for the parallel pressure word output
package pressure_word_pkg;
  typedef enum logic [1:0] {
    fmt_signed,
    fmt_binary,
    fmt_bcd
  } word_format_t;

  typedef struct packed {
    logic        busy;
    logic [20:0] data;
  } word_port_t;
endpackage

// *** core/parallel_pressure_word_output.sv ***
// Parallel pressure word output with busy qualifier
// Behaviour
// - The word and busy pins are driven continuously from reset onward.
// - While busy is high the word is being refreshed and is not to be used.
// - Once busy is low the data lines hold a valid word.
// - All data and busy outputs are active high.
// - Only the signed format has a polarity line; others are non-negative.
// - Signed polarity bit is high for positive, low for vacuum.
// - Signed word spans -32767 to +32767 proportional to full scale.
// - Signed zero pressure gives all value, polarity and busy lines low.
// - Binary format outputs 0 to 65535 proportional to pressure.
// - Binary zero gives all sixteen value lines and busy low.
// - Decimal format outputs 0 to 100000 proportional to pressure.
// - Decimal zero gives all lines low; full scale sets only the top line.
// - Out-of-range values saturate; there is no range flag.
`timescale 1ns/1ps
`default_nettype none
`include "pressure_word_cfg.svh"
module parallel_pressure_word_output
  import pressure_word_pkg::*;
#(
  parameter word_format_t FORMAT = fmt_signed
) (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  // Measurement in: signed sample scaled to full scale (+/-2^17)
  input  wire logic               sample_valid_in,
  input  wire logic signed [17:0] sample_in,
  // Parallel port
  output var  logic [20:0]        word_out,
  output var  logic               busy_out
);
  // Update sequence: raise busy, load the word, let it settle, drop busy
  typedef enum logic [1:0] {
    st_idle,
    st_raise,
    st_load,
    st_settle
  } port_state_t;

  localparam logic [7:0]         SETTLE    = 8'(`PW_SETTLE_CYC);
  localparam logic signed [17:0] SIGNED_HI = 18'(`PW_SIGNED_MAX);
  localparam logic signed [17:0] SIGNED_LO = 18'(`PW_SIGNED_MIN);
  localparam logic signed [17:0] BIN_HI    = 18'(`PW_BIN_MAX);
  localparam logic signed [17:0] BCD_HI    = 18'(`PW_BCD_MAX);
  localparam logic [16:0]        BCD_FULL  = `PW_BCD_MAX;

  // Update state
  port_state_t        state_r;
  logic [7:0]         cnt_r;
  logic               load_now;
  logic               settle_done;

  // Newest sample waiting for the port
  logic signed [17:0] pend_r;
  logic               pend_v_r;

  // Conversion paths
  logic signed [17:0] sgn_clip;
  logic [15:0]        sgn_word;
  logic [16:0]        bin_mag;
  logic [16:0]        bcd_mag;
  wire  logic [19:0]  bcd_digits;
  logic [20:0]        conv_nxt;

  assign load_now    = (state_r == st_load);
  assign settle_done = (state_r == st_settle) && (cnt_r <= 8'd1);

  // Saturation is the only out-of-range sign the reader ever gets
  always_comb begin
    sgn_clip = pend_r;
    if (pend_r > SIGNED_HI) begin
      sgn_clip = SIGNED_HI;
    end else if (pend_r < SIGNED_LO) begin
      sgn_clip = SIGNED_LO;
    end
  end

  // Bit 15 is polarity, high only when above zero so zero stays all low
  always_comb begin
    sgn_word = sgn_clip[15:0];
    if (sgn_clip > 18'sd0) begin
      sgn_word[15] = 1'b1;
    end else begin
      sgn_word[15] = 1'b0;
    end
  end

  always_comb begin
    if (pend_r < 18'sd0) begin
      bin_mag = '0;
    end else if (pend_r > BIN_HI) begin
      bin_mag = `PW_BIN_MAX;
    end else begin
      bin_mag = pend_r[16:0];
    end
  end

  always_comb begin
    if (pend_r < 18'sd0) begin
      bcd_mag = '0;
    end else if (pend_r > BCD_HI) begin
      bcd_mag = BCD_FULL;
    end else begin
      bcd_mag = pend_r[16:0];
    end
  end

  // A divider per digit costs area, not latency
  for (genvar d = 0; d < `PW_BCD_DIGITS; d++) begin : g_digit
    assign bcd_digits[d*4 +: 4] = 4'((bcd_mag / 17'(10 ** d)) % 17'd10);
  end

  always_comb begin
    conv_nxt = `PW_ZERO_WORD;
    case (FORMAT)
      fmt_signed: begin
        conv_nxt = {5'h00, sgn_word};
      end
      fmt_binary: begin
        conv_nxt = {5'h00, bin_mag[15:0]};
      end
      default: begin
        // Full scale is a lone top line
        if (bcd_mag == BCD_FULL) begin
          conv_nxt = 21'h100000;
        end else begin
          conv_nxt = {1'b0, bcd_digits};
        end
      end
    endcase
  end

  // Capture newest sample until the port takes it; a new sample wins
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end else if (sample_valid_in) begin
      pend_r   <= sample_in;
      pend_v_r <= 1'b1;
    end else if (load_now) begin
      pend_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: begin
          if (pend_v_r) begin
            state_r <= st_raise;
          end
        end
        st_raise: begin
          // Two busy cycles, raise and load, before any data line moves
          state_r <= st_load;
        end
        st_load: begin
          state_r <= st_settle;
        end
        default: begin
          if (settle_done) begin
            state_r <= st_idle;
          end
        end
      endcase
    end
  end

  // Settle count lets slow readers see stable lines before busy drops
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (load_now) begin
      cnt_r <= SETTLE;
    end else if ((state_r == st_settle) && !settle_done) begin
      cnt_r <= cnt_r - 8'd1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else if ((state_r == st_idle) && pend_v_r) begin
      busy_out <= 1'b1;
    end else if (settle_done) begin
      busy_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      word_out <= `PW_ZERO_WORD;
    end else if (load_now) begin
      word_out <= conv_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verification/pressure_word_decoder.sv ***
// Decoder model latching the word while busy is low
`timescale 1ns/1ps
`default_nettype none
module pressure_word_decoder (
  input  wire logic        clock_in,
  input  wire logic        busy_in,
  input  wire logic [20:0] word_in,
  output var  logic [20:0] seen_out
);
  // Sampling during busy could catch a torn word
  always_ff @(posedge clock_in) if (!busy_in) seen_out <= word_in;
endmodule
`default_nettype wire

// *** verification/parallel_pressure_word_output_checker.sv ***
// Port checker for the parallel pressure word
`timescale 1ns/1ps
`default_nettype none
module pw_checker
  import pressure_word_pkg::*;
#(
  parameter word_format_t FORMAT = fmt_signed
) (
  input wire logic               clock_in,
  input wire logic               rst_in,
  input wire logic               sample_valid_in,
  input wire logic signed [17:0] sample_in,
  input wire logic [20:0]        word_out,
  input wire logic               busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_word_busy: assert property ($changed(word_out) |-> busy_out)
    else $error("word moved idle");
  a_busy_holds: assert property ($rose(busy_out) |-> busy_out[*5])
    else $error("busy short");
  a_busy_follows: assert property (
    sample_valid_in && !busy_out |-> ##[1:4] busy_out) else $error("no busy");
  a_busy_ends: assert property ($rose(busy_out) |-> ##[5:12] !busy_out)
    else $error("busy stuck");
  a_top_clear: assert property (
    FORMAT == fmt_bcd || word_out[20:16] == 5'h00)
    else $error("top lines set");
  a_no_minimum: assert property (
    FORMAT != fmt_signed || word_out[15:0] != 16'h8000)
    else $error("out of span");
  a_full_alone: assert property (
    word_out[20] |-> word_out[19:0] == 20'h00000)
    else $error("full scale not alone");
  a_bcd_digits: assert property (
    FORMAT == fmt_bcd |-> word_out[3:0] <= 4'h9 && word_out[7:4] <= 4'h9
      && word_out[11:8] <= 4'h9 && word_out[15:12] <= 4'h9
      && word_out[19:16] <= 4'h9) else $error("bad digit");
  a_pol_follows: assert property (
    FORMAT == fmt_signed && sample_valid_in && !busy_out
    ##1 !sample_valid_in[*8]
    |-> word_out[15] == ($past(sample_in, 8) > 18'sd0)) else $error("polarity");
  a_reset_clears: assert property (disable iff (1'b0)
    rst_in |-> word_out == 21'h000000 && !busy_out) else $error("reset");
  cover property ($rose(busy_out));
  cover property ($fell(busy_out) && word_out[15]);
  cover property ($fell(busy_out) && !word_out[15]);
endmodule
bind parallel_pressure_word_output pw_checker #(.FORMAT(FORMAT)) i_pw_checker (
  .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
  .sample_in(sample_in), .word_out(word_out), .busy_out(busy_out));
`default_nettype wire

// *** verification/parallel_pressure_word_output_bench.sv ***
// Self-checking bench for the parallel pressure word
`timescale 1ns/1ps
`default_nettype none
module parallel_pressure_word_output_bench;
  import pressure_word_pkg::*;
  logic               clock_in = 1'b0;
  logic               rst_in = 1'b0;
  logic               sample_valid_in = 1'b0;
  logic signed [17:0] sample_in = 18'h00000;
  logic [20:0]        word_out, seen, word_bin, word_bcd;
  logic               busy_out, busy_bin, busy_bcd;
  int                 fails = 0, n_compared = 0;
  always #10 clock_in = ~clock_in;
  parallel_pressure_word_output #(.FORMAT(fmt_signed))
    i_parallel_pressure_word_output (
    .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .word_out(word_out), .busy_out(busy_out));
  // The other two factory formats see the same stimulus
  parallel_pressure_word_output #(.FORMAT(fmt_binary))
    i_parallel_pressure_word_output_bin (
    .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .word_out(word_bin), .busy_out(busy_bin));
  parallel_pressure_word_output #(.FORMAT(fmt_bcd))
    i_parallel_pressure_word_output_bcd (
    .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .word_out(word_bcd), .busy_out(busy_bcd));
  pressure_word_decoder i_pressure_word_decoder (.clock_in(clock_in),
    .busy_in(busy_out), .word_in(word_out), .seen_out(seen));
  function automatic logic [20:0] enc(input int v);
    int s;
    s = v > 32767 ? 32767 : (v < -32767 ? -32767 : v);
    return {5'h00, s > 0, s[14:0]};
  endfunction
  function automatic logic [20:0] enc_bin(input int v);
    int s;
    s = v > 65535 ? 65535 : (v < 0 ? 0 : v);
    return {5'h00, s[15:0]};
  endfunction
  function automatic logic [20:0] enc_bcd(input int v);
    int s;
    logic [20:0] r;
    s = v > 100000 ? 100000 : (v < 0 ? 0 : v);
    r = 21'h000000;
    if (s == 100000) return 21'h100000;
    for (int i = 0; i < 5; i++) r[i*4 +: 4] = 4'(s / (10 ** i) % 10);
    return r;
  endfunction
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) fails++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic chk_busy(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) fails++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  // Two samples back to back: the newer one must win
  task automatic put(input int v, input int w);
    @(negedge clock_in) {sample_valid_in, sample_in} = {1'b1, 18'(v)};
    @(negedge clock_in) sample_in = 18'(w);
    @(negedge clock_in) sample_valid_in = 1'b0;
    chk_busy(busy_out, 1'b1);
    chk_busy(busy_bcd, 1'b1);
    repeat (26) @(negedge clock_in);
    chk_busy(busy_out, 1'b0);
    chk_busy(busy_bin, 1'b0);
    chk(word_out, enc(w));
    chk(seen, enc(w));
    chk(word_bin, enc_bin(w));
    chk(word_bcd, enc_bcd(w));
  endtask
  task automatic t_limits;
    put(0, 0);
    put(32767, 32767);
    put(-5, -32767);
    put(9, 300);
    put(65535, 65535);
    put(99999, 99999);
    put(3, 100000);
    $display("t_limits done");
  endtask
  task automatic t_saturate;
    put(40000, 40000);
    put(-40000, -40000);
    put(1, 123456);
    $display("t_saturate done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1 rst_in = 1'b1;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    chk(word_out, 21'h000000);
    chk_busy(busy_out, 1'b0);
    t_limits;
    t_saturate;
    tally_and_finish;
  end
  initial begin
    #50000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
